// File: rcsw_pins.sv
// far-side model: master-clear pin and the three wake-capable port pins
// assumes the bench calls its tasks from a process synchronised to clk
`timescale 1ns/10ps
module rcsw_pins
(
  input wire logic clk,
  output logic master_clear_pin_n,
  output logic port_pin_0,
  output logic port_pin_1,
  output logic port_pin_3
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  // reset pin idles high, as its pull-up leaves it
  initial
  begin
    master_clear_pin_n = 1'b1;
    {port_pin_3, port_pin_1, port_pin_0} = 3'b111;
  end
  // ---------------------------------------------------------------
  // pin tasks
  // ---------------------------------------------------------------
  // changes land just after a rising edge, never mid-cycle
  task set_pins(input logic [2:0] v);
    @(posedge clk);
    {port_pin_3, port_pin_1, port_pin_0} <= v;
  endtask
  // split level control so the bench can watch core_reset meanwhile
  task set_clr_pin(input logic v);
    @(posedge clk);
    master_clear_pin_n <= v;
  endtask
endmodule

// File: rcsw_pkg.sv
// package for the reset-cause, sleep and wake block
// assumes a single 40 MHz core clock and an APB register port
package rcsw_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] RCSW_STATUS_OFF = 12'h000;
  localparam logic [11:0] RCSW_CONFIG_OFF = 12'h004;
  localparam logic [11:0] RCSW_CMD_OFF = 12'h008;
  localparam logic [11:0] RCSW_IDLOC_OFF = 12'h010;
  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int RCSW_NPWR_BIT = 3;
  localparam int RCSW_TO_BIT = 4;
  localparam int RCSW_PWF_BIT = 7;
  localparam int RCSW_SLP_BIT = 0;
  // ---------------------------------------------------------------
  // config field positions and reset value
  // ---------------------------------------------------------------
  localparam int RCSW_CFG_WDTEN = 0;
  localparam int RCSW_CFG_MCLREN = 1;
  localparam int RCSW_CFG_WUEN = 2;
  localparam int RCSW_CFG_CP = 3;
  localparam int RCSW_CFG_REVB = 4;
  localparam int RCSW_CFG_PGM = 5;
  localparam logic [5:0] RCSW_CFG_RST = 6'h07;
  // ---------------------------------------------------------------
  // command bits
  // ---------------------------------------------------------------
  localparam int RCSW_CMD_SLEEP = 0;
  localparam int RCSW_CMD_PORTRD = 1;
  localparam int RCSW_CMD_CLRWDT = 2;
  // ---------------------------------------------------------------
  // memory and timing
  // ---------------------------------------------------------------
  localparam int RCSW_PMEM_AW = 10;
  localparam logic [9:0] RCSW_PMEM_LAST = 10'h3ff;
  localparam logic [9:0] RCSW_OPEN_LOCS = 10'h040;
  localparam int RCSW_ID_N = 4;
  localparam int RCSW_WDOG_NS = 18000000;
  localparam int RCSW_CLK_MHZ = 40;
  localparam int RCSW_WDOG_CYC = RCSW_WDOG_NS / 1000 * RCSW_CLK_MHZ;
  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCSW_RUN = 2'b01,
    RCSW_SLEEP = 2'b10
  } rcsw_state_t;
endpackage

// File: rcsw_top.sv
// reset-cause flags, sleep entry, wake-up and code-protect readout gate
// assumes APB master on clk, asynchronous port pins and reset pin
//
// Overview of operation
// - watchdog timeout while running clears pin-wake and not-timeout, keeps powerdown.
// - master-clear while running clears pin-wake only, other flags unchanged.
// - pin change wake sets pin-wake and not-timeout, clears not-powerdown.
// - power-up sets not-timeout and not-powerdown, clears pin-wake.
// - watchdog timeout clears not-timeout; from sleep powerdown clear, pin-wake zero.
// - flags hold until a reset or sleep; a master-clear pulse alone clears only pin-wake.
// - sleep command enters low-power halt.
// - on sleep clear watchdog, set not-timeout, clear not-powerdown, stop oscillator.
// - port drive states are held frozen during halt.
// - watchdog reset stays internal, never drives the master-clear pin.
// - wake on master-clear, watchdog timeout, or port pins 0,1,3 change.
// - every wake produces a full device reset.
// - pin-wake flags a change on pins 0,1,3 during halt.
// - compare against last port read; stale mismatch wakes at once.
// - watchdog cleared on every wake.
// - unprotected part allows full program memory readout.
// - first 64 locations readable regardless of protection.
// - last location blocked on early variants when protected, open on revised.
// - four id locations reachable only during program/verify.
`timescale 1ns/10ps
module rcsw_top
  import rcsw_pkg::*;
#(
  parameter int WDOG_CYC = rcsw_pkg::RCSW_WDOG_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clear_pin_n,
  input wire logic port_pin_0,
  input wire logic port_pin_1,
  input wire logic port_pin_3,
  input wire logic [4:0] port_out_in,
  input wire logic [4:0] port_oe_n_in,
  output logic [4:0] port_out,
  output logic [4:0] port_oe_n,
  input wire logic [9:0] pmem_addr,
  output logic pmem_read_ok,
  output logic osc_run,
  output logic core_reset,
  output logic master_clear_oe_n
);
  import rcsw_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers for pins
  // ---------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  // two flops per pin; only sync2 is read by logic
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
    end
    else
    begin
      sync1_q <= {master_clear_pin_n, port_pin_3, port_pin_1, port_pin_0};
      sync2_q <= sync1_q;
    end
  end
  logic [2:0] pins_s;
  logic nrst_s;
  assign pins_s = sync2_q[2:0];
  assign nrst_s = sync2_q[3];

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  rcsw_state_t state_q;
  logic to_q;
  logic npwr_q;
  logic pwf_q;
  logic [5:0] cfg_q;
  logic [2:0] latch_q;
  logic nrst_prev_q;
  logic [31:0] wdog_q;
  logic [11:0] id_q [RCSW_ID_N];
  logic [4:0] hold_out_q;
  logic [4:0] hold_oe_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  assign acc = psel && penable;
  assign wr = acc && pwrite;

  // id index decode shared by read and write
  function automatic logic id_hit(input logic [11:0] a);
    id_hit = (a >= RCSW_IDLOC_OFF) && (a < RCSW_IDLOC_OFF + 12'h010) && (a[1:0] == 2'b00);
  endfunction

  logic cmd_sleep;
  logic cmd_portrd;
  logic cmd_clrwdt;
  assign cmd_sleep = wr && (paddr == RCSW_CMD_OFF) && pwdata[RCSW_CMD_SLEEP];
  assign cmd_portrd = wr && (paddr == RCSW_CMD_OFF) && pwdata[RCSW_CMD_PORTRD];
  assign cmd_clrwdt = wr && (paddr == RCSW_CMD_OFF) && pwdata[RCSW_CMD_CLRWDT];

  // ---------------------------------------------------------------
  // wake and reset events
  // ---------------------------------------------------------------
  logic wdog_en;
  logic nrst_en;
  logic wu_en;
  logic sleeping;
  logic wdog_to;
  logic nrst_fall;
  logic pin_chg;
  assign wdog_en = cfg_q[RCSW_CFG_WDTEN];
  assign nrst_en = cfg_q[RCSW_CFG_MCLREN];
  assign wu_en = cfg_q[RCSW_CFG_WUEN];
  assign sleeping = (state_q == RCSW_SLEEP);
  assign wdog_to = wdog_en && (wdog_q >= WDOG_CYC - 1);
  assign nrst_fall = nrst_en && nrst_prev_q && !nrst_s;
  // stale mismatch from before sleep wakes immediately
  assign pin_chg = sleeping && wu_en && (pins_s != latch_q);

  logic wake;
  assign wake = sleeping && (nrst_fall || wdog_to || pin_chg);

  // master-clear edge detector on synchronised level
  always_ff @(posedge clk)
  begin
    if (!rstn)
      nrst_prev_q <= 1'b1;
    else
      nrst_prev_q <= nrst_s;
  end

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      state_q <= RCSW_RUN;
    else
    begin
      case (state_q)
        RCSW_RUN:
          if (cmd_sleep)
            state_q <= RCSW_SLEEP;
        RCSW_SLEEP:
          if (wake)
            state_q <= RCSW_RUN;
        default:
          state_q <= RCSW_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // watchdog counter
  // ---------------------------------------------------------------
  // runs on core clock in sleep too, as if its own oscillator
  always_ff @(posedge clk)
  begin
    if (!rstn)
      wdog_q <= 32'h0;
    else if (cmd_sleep || wake || wdog_to || cmd_clrwdt || !wdog_en)
      wdog_q <= 32'h0;
    else
      wdog_q <= wdog_q + 32'h1;
  end

  // ---------------------------------------------------------------
  // reset-cause flags
  // ---------------------------------------------------------------
  // rstn acts as the power-up reset; a master-clear pulse is separate
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      to_q <= 1'b1;
      npwr_q <= 1'b1;
      pwf_q <= 1'b0;
    end
    else if (wdog_to)
    begin
      to_q <= 1'b0;
      pwf_q <= 1'b0;
    end
    else if (wake && pin_chg)
    begin
      to_q <= 1'b1;
      npwr_q <= 1'b0;
      pwf_q <= 1'b1;
    end
    else if (nrst_fall)
      pwf_q <= 1'b0;
    else if (cmd_sleep && !sleeping)
    begin
      to_q <= 1'b1;
      npwr_q <= 1'b0;
    end
  end // otherwise flags hold

  // ---------------------------------------------------------------
  // port latch and drive hold
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
      latch_q <= 3'h0;
    else if (cmd_portrd && !sleeping)
      latch_q <= pins_s;
  end

  // outputs frozen while halted
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hold_out_q <= 5'h00;
      hold_oe_q <= 5'h1f;
    end
    else if (!sleeping)
    begin
      hold_out_q <= port_out_in;
      hold_oe_q <= port_oe_n_in;
    end
  end
  assign port_out = hold_out_q;
  assign port_oe_n = hold_oe_q;

  // ---------------------------------------------------------------
  // core reset, oscillator, master-clear pin
  // ---------------------------------------------------------------
  logic rst_pulse_q;
  logic osc_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rst_pulse_q <= 1'b1;
      osc_q <= 1'b1;
    end
    else
    begin
      rst_pulse_q <= wake || wdog_to || nrst_fall;
      osc_q <= !(cmd_sleep || (sleeping && !wake));
    end
  end
  assign core_reset = rst_pulse_q;
  assign osc_run = osc_q;
  // pin is input only; watchdog reset never drives it
  logic nrst_oe_q;
  always_ff @(posedge clk)
  begin
    nrst_oe_q <= 1'b1;
  end
  assign master_clear_oe_n = nrst_oe_q;

  // ---------------------------------------------------------------
  // code protect gate
  // ---------------------------------------------------------------
  logic cp;
  logic rd_ok_q;
  assign cp = cfg_q[RCSW_CFG_CP];
  always_ff @(posedge clk)
  begin
    if (!rstn)
      rd_ok_q <= 1'b0;
    else if (!cp)
      rd_ok_q <= 1'b1;
    else if (pmem_addr < RCSW_OPEN_LOCS)
      rd_ok_q <= 1'b1;
    else if (pmem_addr == RCSW_PMEM_LAST)
      rd_ok_q <= cfg_q[RCSW_CFG_REVB];
    else
      rd_ok_q <= 1'b0;
  end
  assign pmem_read_ok = rd_ok_q;

  // ---------------------------------------------------------------
  // config and id locations
  // ---------------------------------------------------------------
  logic pgm;
  assign pgm = cfg_q[RCSW_CFG_PGM];
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cfg_q <= RCSW_CFG_RST;
    else if (wr && paddr == RCSW_CONFIG_OFF)
      cfg_q <= pwdata[5:0];
  end

  // id words written only in program mode; upper bits kept as given
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < RCSW_ID_N; i++)
        id_q[i] <= 12'h000;
    end
    else if (wr && pgm && id_hit(paddr))
      id_q[paddr[3:2]] <= pwdata[11:0]; // relies on programmer
  end

  // ---------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------
  logic [31:0] rd_d;
  logic err_d;
  always_comb
  begin
    rd_d = 32'h0;
    err_d = 1'b0;
    if (paddr == RCSW_STATUS_OFF)
    begin
      rd_d[RCSW_NPWR_BIT] = npwr_q;
      rd_d[RCSW_TO_BIT] = to_q;
      rd_d[RCSW_PWF_BIT] = pwf_q;
      rd_d[RCSW_SLP_BIT] = sleeping;
    end
    else if (paddr == RCSW_CONFIG_OFF)
      rd_d[5:0] = cfg_q;
    else if (paddr == RCSW_CMD_OFF)
      rd_d = 32'h0;
    else if (id_hit(paddr))
    begin
      if (pgm)
        rd_d[11:0] = id_q[paddr[3:2]];
      else
        err_d = 1'b1;
    end
    else
      err_d = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && err_d;
      prdata <= (psel && !pwrite) ? rd_d : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  pin_wake_a: assert property (@(posedge clk) disable iff (!rstn)
    (sleeping && pin_chg && !wdog_to && !nrst_fall) |=> (pwf_q && to_q && !npwr_q))
    else $error("pin wake flags wrong");
  wdog_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    wdog_to |=> (!to_q && !pwf_q && $stable(npwr_q)))
    else $error("watchdog flags wrong");
  sleep_enter_a: assert property (@(posedge clk) disable iff (!rstn)
    (cmd_sleep && !sleeping && !wdog_to && !nrst_fall) |=> (sleeping && to_q && !npwr_q))
    else $error("sleep entry wrong");
  nrst_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    (nrst_fall && !sleeping && !wdog_to) |=> (!pwf_q && $stable(to_q) && $stable(npwr_q)))
    else $error("master clear flags wrong");
  wake_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    wake |=> (core_reset && !sleeping && wdog_q == 32'h0))
    else $error("wake without reset");
  port_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (sleeping && $past(sleeping)) |-> ($stable(port_out) && $stable(port_oe_n)))
    else $error("ports moved in sleep");
  nrst_drive_a: assert property (@(posedge clk) disable iff (!rstn)
    master_clear_oe_n)
    else $error("master clear driven");
  cp_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (pmem_addr < RCSW_OPEN_LOCS) |=> pmem_read_ok)
    else $error("low locations blocked");
  osc_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    (sleeping && !wake) |=> !osc_run)
    else $error("oscillator running in sleep");
endmodule

// File: tb.sv
// self-checking bench for the reset-cause, sleep and wake block
// assumes zero-wait apb answers and a shortened watchdog count of 50
`timescale 1ns/10ps
module tb;
  import rcsw_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] port_out_in = 5'h00;
  logic [4:0] port_oe_n_in = 5'h1f;
  logic [9:0] pmem_addr = 10'h000;
  logic [31:0] prdata;
  logic pready, pslverr, master_clear_pin_n, port_pin_0, port_pin_1, port_pin_3;
  logic [4:0] port_out;
  logic [4:0] port_oe_n;
  logic pmem_read_ok, osc_run, core_reset, master_clear_oe_n;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] gate_cfg [7] = '{32'h06, 32'h06, 32'h0e, 32'h0e, 32'h0e, 32'h1e, 32'h1e};
  logic [9:0] gate_addr [7] = '{10'h3ff, 10'h200, 10'h03f, 10'h040, 10'h3ff, 10'h3ff, 10'h200};
  logic gate_ok [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  // 40 mhz core clock
  always #12.5 clk = ~clk;
  rcsw_top #(.WDOG_CYC(50)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_clear_pin_n(master_clear_pin_n), .port_pin_0(port_pin_0),
    .port_pin_1(port_pin_1), .port_pin_3(port_pin_3), .port_out_in(port_out_in),
    .port_oe_n_in(port_oe_n_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .pmem_addr(pmem_addr), .pmem_read_ok(pmem_read_ok), .osc_run(osc_run),
    .core_reset(core_reset), .master_clear_oe_n(master_clear_oe_n));
  rcsw_pins pt (.clk(clk), .master_clear_pin_n(master_clear_pin_n), .port_pin_0(port_pin_0),
    .port_pin_1(port_pin_1), .port_pin_3(port_pin_3));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task results();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  // one apb transfer; reads after an edge see the values sampled there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      results();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0);
  endtask
  // bounded wait for the reset pulse; the pin must stay undriven
  task wait_rst(input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (core_reset !== 1'b1 && n < lim);
    chk({31'h0, core_reset}, 32'h1);
    chk({31'h0, master_clear_oe_n}, 32'h1);
    if (core_reset !== 1'b1)
      results();
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(RCSW_STATUS_OFF, 32'h18);
    rd_chk(RCSW_CONFIG_OFF, 32'h07);
    // watchdog runs out while awake: pd kept from power-up
    wait_rst(80);
    rd_chk(RCSW_STATUS_OFF, 32'h08);
    wr(RCSW_CONFIG_OFF, 32'h06);
    // sleep entry freezes the port drive
    port_out_in <= 5'h0a;
    port_oe_n_in <= 5'h14;
    wr(RCSW_CMD_OFF, 32'h2);
    wr(RCSW_CMD_OFF, 32'h1);
    port_out_in <= 5'h15;
    port_oe_n_in <= 5'h0b;
    repeat (3) @(posedge clk);
    chk({31'h0, osc_run}, 32'h0);
    chk({27'h0, port_out}, 32'h0a);
    chk({27'h0, port_oe_n}, 32'h14);
    rd_chk(RCSW_STATUS_OFF, 32'h11);
    // master-clear wakes from sleep
    pt.set_clr_pin(1'b0);
    wait_rst(20);
    pt.set_clr_pin(1'b1);
    rd_chk(RCSW_STATUS_OFF, 32'h10);
    // 90 cycles total only pass if sleep entry and wake both clear the dog
    wr(RCSW_CONFIG_OFF, 32'h07);
    wr(RCSW_CMD_OFF, 32'h4);
    repeat (30) @(posedge clk);
    wr(RCSW_CMD_OFF, 32'h2);
    wr(RCSW_CMD_OFF, 32'h1);
    repeat (30) @(posedge clk);
    pt.set_pins(3'b110);
    wait_rst(20);
    repeat (30) @(posedge clk);
    rd_chk(RCSW_STATUS_OFF, 32'h90);
    wr(RCSW_CONFIG_OFF, 32'h06);
    // pins not read again: sleep ends at once
    wr(RCSW_CMD_OFF, 32'h1);
    wait_rst(10);
    rd_chk(RCSW_STATUS_OFF, 32'h90);
    // master-clear while awake drops only pin-wake
    pt.set_clr_pin(1'b0);
    repeat (6) @(posedge clk);
    pt.set_clr_pin(1'b1);
    repeat (4) @(posedge clk);
    rd_chk(RCSW_STATUS_OFF, 32'h10);
    // watchdog wakes from sleep
    wr(RCSW_CMD_OFF, 32'h2);
    wr(RCSW_CONFIG_OFF, 32'h07);
    wr(RCSW_CMD_OFF, 32'h1);
    wait_rst(80);
    rd_chk(RCSW_STATUS_OFF, 32'h00);
    // wake sources switched off: pin 3 and master-clear moves must not wake
    wr(RCSW_CONFIG_OFF, 32'h00);
    wr(RCSW_CMD_OFF, 32'h1);
    pt.set_pins(3'b010);
    pt.set_clr_pin(1'b0);
    repeat (6) @(posedge clk);
    pt.set_clr_pin(1'b1);
    repeat (4) @(posedge clk);
    rd_chk(RCSW_STATUS_OFF, 32'h11);
    // enabling wake-on-change with pin 3 already moved wakes at once
    wr(RCSW_CONFIG_OFF, 32'h04);
    wait_rst(10);
    chk({31'h0, osc_run}, 32'h1);
    rd_chk(RCSW_STATUS_OFF, 32'h90);
    // pin 1 alone wakes after a fresh capture
    wr(RCSW_CMD_OFF, 32'h2);
    wr(RCSW_CMD_OFF, 32'h1);
    repeat (4) @(posedge clk);
    pt.set_pins(3'b000);
    wait_rst(20);
    rd_chk(RCSW_STATUS_OFF, 32'h90);
    // readout gate over protection settings and variants
    for (int i = 0; i < 7; i++)
    begin
      wr(RCSW_CONFIG_OFF, gate_cfg[i]);
      pmem_addr <= gate_addr[i];
      repeat (3) @(posedge clk);
      chk({31'h0, pmem_read_ok}, {31'h0, gate_ok[i]});
    end
    // id words only in program/verify; unmapped place refused
    wr(RCSW_CONFIG_OFF, 32'h06);
    apb(1'b0, RCSW_IDLOC_OFF, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(RCSW_CONFIG_OFF, 32'h26);
    wr(RCSW_IDLOC_OFF + 12'h004, 32'h00a);
    rd_chk(RCSW_IDLOC_OFF + 12'h004, 32'h00a);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    // second power-up in mid-run restores the power-up flags
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    chk({31'h0, core_reset}, 32'h1);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(RCSW_STATUS_OFF, 32'h18);
    rd_chk(RCSW_CONFIG_OFF, 32'h07);
    results();
  end
endmodule
